//--- rtl/ldc_pkg.sv
// Package holding register map, field layout, reset values and carrier types
package ldc_pkg;

    // SMBus target address; the value is arbitrary
    localparam logic [6:0] SMB_DEV_ADDR = 7'h2d;
    localparam logic [3:0] SMB_BITS = 4'h8;

    // Register offsets
    localparam logic [7:0] ADDR_GEN_CTRL = 8'h20;
    localparam logic [7:0] ADDR_DRV_CTRL = 8'h27;
    localparam logic [7:0] ADDR_CLK_CTRL = 8'h28;
    localparam logic [7:0] ADDR_EVT_CFG = 8'h2b;
    localparam logic [7:0] ADDR_EVT_CNT = 8'h3d;

    // Field positions
    localparam int GEN_RESET_BIT = 1;
    localparam int GEN_PWRDN_BIT = 0;
    localparam int DRV_SWING_BIT = 7;
    localparam int DRV_MGMT_BIT = 6;
    localparam int DRV_CLK_BIT = 5;
    localparam int DRV_LANE_HI = 4;
    localparam int CLK_RATE_BIT = 5;
    localparam int CLK_INV_BIT = 4;
    localparam int CLK_DLY_HI = 3;
    localparam int CLK_DLY_LO = 2;
    localparam int EVT_SEL_BIT = 3;
    localparam int EVT_CLR_REC_BIT = 2;
    localparam int EVT_CLR_LINK_BIT = 1;
    localparam int EVT_EN_BIT = 0;

    // Reset values and masks of stored bits
    localparam logic [7:0] GEN_RST = 8'h00;
    localparam logic [7:0] DRV_RST = 8'h00;
    localparam logic [7:0] CLK_RST = 8'h28;
    localparam logic [7:0] EVT_RST = 8'h00;
    localparam logic [7:0] GEN_MASK = 8'h03;
    localparam logic [7:0] CLK_MASK = 8'h3c;
    localparam logic [7:0] EVT_MASK = 8'h09;

    // Delay added per step of the forwarded clock delay field, in ps
    localparam logic [7:0] DELAY_STEP_PS = 8'h50;

    localparam int NUM_LANES = 5;
    localparam int NUM_EVT_CNT = 2;
    localparam int CNT_W = 8;
    localparam logic [CNT_W-1:0] CNT_MAX = 8'hff;

    typedef struct packed {
        logic output_swing_boost;
        logic clock_driver_en;
        logic [NUM_LANES-1:0] lane_driver_en;
    } ldc_drv_s;

    typedef struct packed {
        logic clock_rate_select;
        logic clock_polarity_invert;
        logic [1:0] delay_steps;
        logic [7:0] delay_ps;
    } ldc_clk_s;

endpackage : ldc_pkg

//--- rtl/ldc_evt_cnt.sv
// Saturating event counter with input synchronisers, enable and clear
`timescale 1ns/1ps
module ldc_evt_cnt
    import ldc_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Event levels from outside the clock domain
    input wire logic [1:0] evt_raw,
    // Control
    input wire logic count_en,
    input wire logic clear,
    // Count
    output logic [CNT_W-1:0] count
);

    logic [1:0] ev_m;
    logic [1:0] ev_s;
    logic [1:0] ev_d;
    logic ev_edge;
    logic [CNT_W-1:0] next_count;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ev_m <= 2'h0;
            ev_s <= 2'h0;
            ev_d <= 2'h0;
        end else begin
            ev_m <= evt_raw;
            ev_s <= ev_m;
            ev_d <= ev_s;
        end
    end

    // Coincident edges on both sources count once
    assign ev_edge = |(ev_s & ~ev_d);

    always_comb begin
        next_count = count;
        if (clear) begin
            // An event in the clearing cycle survives as a count of one
            next_count = (ev_edge && count_en) ? 8'h01 : 8'h00;
        end else if (ev_edge && count_en && count != CNT_MAX) begin
            next_count = count + 8'h01;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            count <= 8'h00;
        end else begin
            count <= next_count;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    count_inc_a: assert property (ev_edge && count_en && !clear && count != CNT_MAX
        |=> count == $past(count) + 8'h01) else $error("event not counted");
    count_clr_a: assert property (clear ##1 !clear [*2] |-> count <= 8'h03)
        else $error("clear left a stale count");
    count_hold_a: assert property (!count_en && !clear |=> $stable(count))
        else $error("counter moved while disabled");

endmodule : ldc_evt_cnt

//--- rtl/ldc_regs.sv
// Output driver, forwarded clock and event counter configuration behind SMBus
`timescale 1ns/1ps
module ldc_regs
    import ldc_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // SMBus management pins
    input wire logic smb_scl,
    input wire logic smb_sda_in,
    output logic smb_sda_out,
    output logic smb_sda_oe,
    // Pin-determined driver enables, {clock, lane4..lane0}
    input wire logic [5:0] default_driver_en,
    // Event sources
    input wire logic clock_lost,
    input wire logic lock_lost,
    input wire logic link_error,
    // Configuration outputs
    output ldc_drv_s drv,
    output ldc_clk_s clk_cfg,
    output logic channel_reset,
    output logic digital_powerdown,
    output logic [CNT_W-1:0] selected_event_count
);

    typedef enum {
        SM_IDLE, SM_ADDR, SM_AACK, SM_PTR, SM_PACK, SM_WR, SM_WACK, SM_RD, SM_RACK
    } ldc_smb_state_e;

    // Pin synchronisers
    logic scl_m, scl_s, scl_d;
    logic sda_m, sda_s, sda_d;
    logic [5:0] def_m, def_s;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            scl_m <= 1'b1;
            scl_s <= 1'b1;
            scl_d <= 1'b1;
            sda_m <= 1'b1;
            sda_s <= 1'b1;
            sda_d <= 1'b1;
            def_m <= 6'h00;
            def_s <= 6'h00;
        end else begin
            scl_m <= smb_scl;
            scl_s <= scl_m;
            scl_d <= scl_s;
            sda_m <= smb_sda_in;
            sda_s <= sda_m;
            sda_d <= sda_s;
            def_m <= default_driver_en;
            def_s <= def_m;
        end
    end

    logic scl_rise, scl_fall, smb_start, smb_stop;
    assign scl_rise = scl_s & ~scl_d;
    assign scl_fall = ~scl_s & scl_d;
    assign smb_start = scl_s & scl_d & sda_d & ~sda_s;
    assign smb_stop = scl_s & scl_d & ~sda_d & sda_s;

    // SMBus target engine
    ldc_smb_state_e state, next_state;
    logic [3:0] bitcnt, next_bitcnt;
    logic [7:0] shreg, next_shreg;
    logic [7:0] ptr, next_ptr;
    logic rw, next_rw;
    logic nack, next_nack;
    logic next_oe;
    logic wr_en;
    logic [7:0] rdata;

    // Registers
    logic [7:0] gen_ctrl, next_gen_ctrl;
    logic [7:0] drv_ctrl, next_drv_ctrl;
    logic [7:0] clk_ctrl, next_clk_ctrl;
    logic [7:0] evt_cfg, next_evt_cfg;
    logic [NUM_EVT_CNT-1:0] cnt_clear;
    logic [CNT_W-1:0] cnt [NUM_EVT_CNT];
    ldc_drv_s next_drv;
    ldc_clk_s next_clk_cfg;
    logic [CNT_W-1:0] next_selected;

    always_comb begin
        rdata = 8'h00;
        case (ptr)
            ADDR_GEN_CTRL: rdata = gen_ctrl;
            ADDR_DRV_CTRL: rdata = drv_ctrl;
            ADDR_CLK_CTRL: rdata = clk_ctrl;
            ADDR_EVT_CFG: rdata = evt_cfg;
            ADDR_EVT_CNT: rdata = selected_event_count;
            default: rdata = 8'h00;
        endcase
    end

    always_comb begin
        next_state = state;
        next_bitcnt = bitcnt;
        next_shreg = shreg;
        next_ptr = ptr;
        next_rw = rw;
        next_nack = nack;
        next_oe = smb_sda_oe;
        wr_en = 1'b0;
        if (smb_start) begin
            next_state = SM_ADDR;
            next_bitcnt = 4'h0;
            next_oe = 1'b0;
        end else if (smb_stop) begin
            next_state = SM_IDLE;
            next_oe = 1'b0;
        end else begin
            case (state)
                SM_ADDR, SM_PTR, SM_WR: begin
                    if (scl_rise) begin
                        next_shreg = {shreg[6:0], sda_s};
                        next_bitcnt = bitcnt + 4'h1;
                    end else if (scl_fall && bitcnt == SMB_BITS) begin
                        next_oe = 1'b1;
                        next_bitcnt = 4'h0;
                        if (state == SM_ADDR) begin
                            if (shreg[7:1] == SMB_DEV_ADDR) begin
                                next_rw = shreg[0];
                                next_state = SM_AACK;
                            end else begin
                                next_oe = 1'b0;
                                next_state = SM_IDLE;
                            end
                        end else if (state == SM_PTR) begin
                            next_ptr = shreg;
                            next_state = SM_PACK;
                        end else begin
                            wr_en = 1'b1;
                            next_state = SM_WACK;
                        end
                    end
                end
                SM_AACK: begin
                    if (scl_fall) begin
                        if (rw) begin
                            next_shreg = rdata;
                            next_oe = ~rdata[7];
                            next_state = SM_RD;
                        end else begin
                            next_oe = 1'b0;
                            next_state = SM_PTR;
                        end
                    end
                end
                SM_PACK, SM_WACK: begin
                    if (scl_fall) begin
                        next_oe = 1'b0;
                        next_state = SM_WR;
                        if (state == SM_WACK) begin
                            next_ptr = ptr + 8'h01;
                        end
                    end
                end
                SM_RD: begin
                    if (scl_rise) begin
                        next_bitcnt = bitcnt + 4'h1;
                    end else if (scl_fall) begin
                        if (bitcnt == SMB_BITS) begin
                            next_oe = 1'b0;
                            next_bitcnt = 4'h0;
                            next_ptr = ptr + 8'h01;
                            next_state = SM_RACK;
                        end else begin
                            next_shreg = {shreg[6:0], 1'b0};
                            next_oe = ~shreg[6];
                        end
                    end
                end
                SM_RACK: begin
                    if (scl_rise) begin
                        next_nack = sda_s;
                    end else if (scl_fall) begin
                        if (nack) begin
                            next_state = SM_IDLE;
                        end else begin
                            next_shreg = rdata;
                            next_oe = ~rdata[7];
                            next_state = SM_RD;
                        end
                    end
                end
                default: next_state = SM_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state <= SM_IDLE;
            bitcnt <= 4'h0;
            shreg <= 8'h00;
            ptr <= 8'h00;
            rw <= 1'b0;
            nack <= 1'b0;
            smb_sda_oe <= 1'b0;
        end else begin
            state <= next_state;
            bitcnt <= next_bitcnt;
            shreg <= next_shreg;
            ptr <= next_ptr;
            rw <= next_rw;
            nack <= next_nack;
            smb_sda_oe <= next_oe;
        end
    end

    // Open-drain: only ever pulls low
    assign smb_sda_out = 1'b0;

    // Register file and derived outputs
    always_comb begin
        next_gen_ctrl = gen_ctrl;
        next_drv_ctrl = drv_ctrl;
        next_clk_ctrl = clk_ctrl;
        next_evt_cfg = evt_cfg;
        cnt_clear = '0;
        if (wr_en) begin
            case (ptr)
                ADDR_GEN_CTRL: next_gen_ctrl = shreg & GEN_MASK;
                ADDR_DRV_CTRL: next_drv_ctrl = shreg;
                ADDR_CLK_CTRL: next_clk_ctrl = shreg & CLK_MASK;
                ADDR_EVT_CFG: begin
                    // Clear bits act on the write and are not stored
                    next_evt_cfg = shreg & EVT_MASK;
                    cnt_clear[0] = shreg[EVT_CLR_REC_BIT];
                    cnt_clear[1] = shreg[EVT_CLR_LINK_BIT];
                end
                default: ;
            endcase
        end
        next_drv.output_swing_boost = next_drv_ctrl[DRV_SWING_BIT];
        if (next_drv_ctrl[DRV_MGMT_BIT]) begin
            next_drv.clock_driver_en = next_drv_ctrl[DRV_CLK_BIT];
            next_drv.lane_driver_en = next_drv_ctrl[DRV_LANE_HI:0];
        end else begin
            next_drv.clock_driver_en = def_s[5];
            next_drv.lane_driver_en = def_s[DRV_LANE_HI:0];
        end
        next_clk_cfg.clock_rate_select = next_clk_ctrl[CLK_RATE_BIT];
        next_clk_cfg.clock_polarity_invert = next_clk_ctrl[CLK_INV_BIT];
        next_clk_cfg.delay_steps = next_clk_ctrl[CLK_DLY_HI:CLK_DLY_LO];
        next_clk_cfg.delay_ps = DELAY_STEP_PS * {6'h00, next_clk_cfg.delay_steps};
        next_selected = evt_cfg[EVT_SEL_BIT] ? cnt[1] : cnt[0];
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            gen_ctrl <= GEN_RST;
            drv_ctrl <= DRV_RST;
            clk_ctrl <= CLK_RST;
            evt_cfg <= EVT_RST;
            drv <= '0;
            clk_cfg <= '{CLK_RST[CLK_RATE_BIT], CLK_RST[CLK_INV_BIT],
                CLK_RST[CLK_DLY_HI:CLK_DLY_LO],
                DELAY_STEP_PS * {6'h00, CLK_RST[CLK_DLY_HI:CLK_DLY_LO]}};
            selected_event_count <= 8'h00;
        end else begin
            gen_ctrl <= next_gen_ctrl;
            drv_ctrl <= next_drv_ctrl;
            clk_ctrl <= next_clk_ctrl;
            evt_cfg <= next_evt_cfg;
            drv <= next_drv;
            clk_cfg <= next_clk_cfg;
            selected_event_count <= next_selected;
        end
    end

    assign channel_reset = gen_ctrl[GEN_RESET_BIT];
    assign digital_powerdown = gen_ctrl[GEN_PWRDN_BIT];

    // Counter 0: clock recovery events, counter 1: data link events
    logic [1:0] evt_src [NUM_EVT_CNT];
    assign evt_src[0] = {lock_lost, clock_lost};
    assign evt_src[1] = {1'b0, link_error};

    genvar gi;
    generate
        for (gi = 0; gi < NUM_EVT_CNT; gi++) begin : g_cnt
            ldc_evt_cnt u_cnt (
                .mclk(mclk),
                .rst_b(rst_b),
                .evt_raw(evt_src[gi]),
                .count_en(evt_cfg[EVT_EN_BIT]),
                .clear(cnt_clear[gi]),
                .count(cnt[gi])
            );
        end
    endgenerate

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    swing_write_a: assert property (wr_en && ptr == ADDR_DRV_CTRL
        |=> drv.output_swing_boost == $past(shreg[DRV_SWING_BIT])) else $error("swing wrong");
    mgmt_clk_a: assert property (drv_ctrl[DRV_MGMT_BIT] |-> ##1
        (drv.clock_driver_en == $past(drv_ctrl[DRV_CLK_BIT]) || $changed(drv_ctrl)))
        else $error("clock driver enable wrong");
    mgmt_lane_a: assert property (drv_ctrl[DRV_MGMT_BIT] && $stable(drv_ctrl)
        |-> drv.lane_driver_en == drv_ctrl[DRV_LANE_HI:0]) else $error("lane enable wrong");
    default_drv_a: assert property (!drv_ctrl[DRV_MGMT_BIT] && $stable(drv_ctrl)
        |-> drv.lane_driver_en == $past(def_s[DRV_LANE_HI:0])) else $error("defaults ignored");
    rate_write_a: assert property (wr_en && ptr == ADDR_CLK_CTRL
        |=> clk_cfg.clock_rate_select == $past(shreg[CLK_RATE_BIT])) else $error("rate wrong");
    invert_write_a: assert property (wr_en && ptr == ADDR_CLK_CTRL
        |=> clk_cfg.clock_polarity_invert == $past(shreg[CLK_INV_BIT]))
        else $error("polarity wrong");
    delay_ps_a: assert property (clk_cfg.delay_ps == 8'h50 * {6'h00, clk_cfg.delay_steps})
        else $error("delay not 80 ps per step");
    select_cnt_a: assert property (selected_event_count ==
        ($past(evt_cfg[EVT_SEL_BIT]) ? $past(cnt[1]) : $past(cnt[0])))
        else $error("wrong counter presented");
    link_clear_a: assert property (cnt_clear[1] |=> cnt[1] <= 8'h01)
        else $error("link counter not cleared");
    gen_write_a: assert property (wr_en && ptr == ADDR_GEN_CTRL
        |=> channel_reset == $past(shreg[GEN_RESET_BIT])) else $error("reset bit wrong");

endmodule : ldc_regs

//--- dv/ldc_smb_host.sv
// SMBus host model: drives SCL and pulls SDA low as an open-drain master
`timescale 1ns/1ps
module ldc_smb_host
    import ldc_pkg::*;
(
    // Bus wires
    output logic scl,
    output logic sda_pull,
    input wire logic sda,
    // Read results
    output logic [7:0] rd_data,
    output logic rd_done
);
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
        rd_data = 8'h00;
        rd_done = 1'b0;
    end

    // Quarter period of 12 ns gives the 48 ns bus clock; SCL stands still between frames
    task automatic start();
        scl = 1'b0;
        #12 sda_pull = 1'b0;
        #12 scl = 1'b1;
        #24 sda_pull = 1'b1;
        #24;
    endtask : start

    task automatic stop();
        scl = 1'b0;
        #12 sda_pull = 1'b1;
        #12 scl = 1'b1;
        #24 sda_pull = 1'b0;
        #24;
    endtask : stop

    task automatic put_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            scl = 1'b0;
            #12 sda_pull = ~b[i];
            #12 scl = 1'b1;
            #24;
        end
        scl = 1'b0;
        #12 sda_pull = 1'b0;
        #12 scl = 1'b1;
        #12 ack = ~sda;
        #12;
    endtask : put_byte

    // Released SDA reads high through the pull-up, so a missing target shows as 1s
    task automatic get_byte(input logic last, output logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            scl = 1'b0;
            #12 sda_pull = 1'b0;
            #12 scl = 1'b1;
            #12 b[i] = sda;
            #12;
        end
        scl = 1'b0;
        #12 sda_pull = ~last;
        #12 scl = 1'b1;
        #24;
    endtask : get_byte

    // n bytes, low byte first, land in consecutive registers as the pointer steps
    task automatic write_reg(input logic [6:0] dev, input logic [7:0] ptr, input logic [15:0] d,
                             input int n, output logic ack);
        logic a;
        start();
        put_byte({dev, 1'b0}, ack);
        put_byte(ptr, a);
        for (int k = 0; k < n; k++) begin
            put_byte(d[8*k +: 8], a);
        end
        stop();
    endtask : write_reg

    // Master ACKs every byte but the last, which it NACKs before the STOP
    task automatic read_reg(input logic [7:0] ptr, input int n);
        logic a;
        start();
        put_byte({SMB_DEV_ADDR, 1'b0}, a);
        put_byte(ptr, a);
        start();
        put_byte({SMB_DEV_ADDR, 1'b1}, a);
        for (int k = 1; k <= n; k++) begin
            get_byte(k == n, rd_data);
            rd_done = 1'b1;
            #4 rd_done = 1'b0;
        end
        stop();
    endtask : read_reg
endmodule : ldc_smb_host

//--- dv/tb_top.sv
// Self-checking bench for the output and event configuration registers
`timescale 1ns/1ps
module tb_top
    import ldc_pkg::*;
;
    logic mclk, rst_b, smb_scl, host_pull, sda_wire, smb_sda_out, smb_sda_oe, ack;
    logic clock_lost, lock_lost, link_error, channel_reset, digital_powerdown, rd_done;
    logic [5:0] default_driver_en;
    logic [7:0] selected_event_count, rd_data;
    ldc_drv_s drv;
    ldc_clk_s clk_cfg;
    logic [7:0] exp_q[$];
    int fail_count = 0;
    int checks = 0;
    int cycles = 0;

    // Open-drain wire: low if any party pulls
    assign sda_wire = ~(host_pull | (smb_sda_oe & ~smb_sda_out));

    ldc_regs DUT (.mclk(mclk), .rst_b(rst_b), .smb_scl(smb_scl), .smb_sda_in(sda_wire),
        .smb_sda_out(smb_sda_out), .smb_sda_oe(smb_sda_oe),
        .default_driver_en(default_driver_en), .clock_lost(clock_lost),
        .lock_lost(lock_lost), .link_error(link_error), .drv(drv), .clk_cfg(clk_cfg),
        .channel_reset(channel_reset), .digital_powerdown(digital_powerdown),
        .selected_event_count(selected_event_count));

    ldc_smb_host host (.scl(smb_scl), .sda_pull(host_pull), .sda(sda_wire),
        .rd_data(rd_data), .rd_done(rd_done));

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    task automatic wrap_up();
        if (fail_count == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : wrap_up

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            fail_count++;
            wrap_up();
        end
    end

    // Each completed read is matched against the oldest noted expectation
    always @(posedge rd_done) begin
        check(16'(rd_data), (exp_q.size() > 0) ? 16'(exp_q.pop_front()) : 16'hdead);
    end

    task automatic rd(input logic [7:0] ptr, input logic [7:0] e);
        exp_q.push_back(e);
        host.read_reg(ptr, 1);
        @(negedge mclk);
    endtask : rd

    // Eight cycles cover the register update and the pin synchronisers
    task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
        host.write_reg(SMB_DEV_ADDR, ptr, {8'h00, d}, 1, ack);
        repeat (8) @(negedge mclk);
    endtask : wr

    task automatic pulse(input logic [2:0] which);
        {clock_lost, lock_lost, link_error} = which;
        repeat (6) @(negedge mclk);
        {clock_lost, lock_lost, link_error} = 3'b000;
        repeat (6) @(negedge mclk);
    endtask : pulse

    initial begin
        logic [7:0] v;
        rst_b = 1'b0;
        {clock_lost, lock_lost, link_error} = 3'b000;
        default_driver_en = 6'h2a;
        void'($urandom(45302));
        repeat (16) @(negedge mclk);
        rst_b = 1'b1;
        repeat (6) @(negedge mclk);
        check(16'(clk_cfg), 16'({1'b1, 1'b0, 2'b10, 8'ha0}));
        check(16'(drv), 16'({1'b0, 6'h2a}));
        rd(8'h27, 8'h00);
        rd(8'h28, 8'h28);
        rd(8'h2b, 8'h00);
        for (int i = 0; i < 6; i++) begin
            v = 8'($urandom);
            v[6] = i[0];
            default_driver_en = 6'($urandom);
            wr(8'h27, v);
            rd(8'h27, v);
            check(16'(drv), 16'(v[6] ? {v[7], v[5:0]} : {v[7], default_driver_en}));
        end
        for (int d = 0; d < 4; d++) begin
            v = 8'($urandom);
            v[3:2] = 2'(d);
            wr(8'h28, v);
            rd(8'h28, v & 8'h3c);
            check(16'(clk_cfg), 16'({v[5:2], 8'(v[3:2]) * 8'h50}));
        end
        wr(8'h2b, 8'h01);
        repeat (3) pulse(3'b100);
        pulse(3'b010);
        pulse(3'b110);
        repeat (2) pulse(3'b001);
        rd(8'h3d, 8'h05);
        check(16'(selected_event_count), 16'h0005);
        wr(8'h2b, 8'h09);
        rd(8'h3d, 8'h02);
        wr(8'h2b, 8'h08);
        pulse(3'b101);
        rd(8'h3d, 8'h02);
        wr(8'h2b, 8'h0a);
        rd(8'h3d, 8'h00);
        rd(8'h2b, 8'h08);
        wr(8'h2b, 8'h00);
        rd(8'h3d, 8'h05);
        wr(8'h2b, 8'h04);
        rd(8'h3d, 8'h00);
        wr(8'h20, 8'h03);
        check(16'({channel_reset, digital_powerdown}), 16'h3);
        rd(8'h20, 8'h03);
        wr(8'h20, 8'h01);
        check(16'({channel_reset, digital_powerdown}), 16'h1);
        // Burst: the pointer steps from 0x27 to 0x28 on both write and read
        v = 8'($urandom);
        host.write_reg(SMB_DEV_ADDR, 8'h27, {v, ~v}, 2, ack);
        repeat (8) @(negedge mclk);
        check(16'(drv), 16'(v[6] ? {~v[7], default_driver_en} : {~v[7], ~v[5:0]}));
        exp_q.push_back(~v);
        exp_q.push_back(v & 8'h3c);
        host.read_reg(8'h27, 2);
        @(negedge mclk);
        // A foreign address must leave the register untouched
        host.write_reg(7'h2c, 8'h28, {8'h00, ~v}, 1, ack);
        check(16'(ack), 16'h0000);
        rd(8'h28, v & 8'h3c);
        host.write_reg(SMB_DEV_ADDR, 8'h2c, 16'h0055, 1, ack);
        check(16'(ack), 16'h0001);
        rd(8'h2c, 8'h00);
        check(16'(exp_q.size()), 16'h0000);
        wrap_up();
    end
endmodule : tb_top
